/* File: shared/agc_regs.svh */
// register offsets, field positions, reset values and timing, current and level constants
`ifndef AGC_REGS_SVH
`define AGC_REGS_SVH

`define AGC_CTRL_OFS 8'h00
`define AGC_TIME_OFS 8'h04
`define AGC_RATE_OFS 8'h08
`define AGC_STAT_OFS 8'h0c

`define AGC_CTRL_RATIO_BIT 0
`define AGC_CTRL_STEP_LSB 1
`define AGC_CTRL_METHOD_BIT 6
`define AGC_CTRL_RST 32'h0000_0000
`define AGC_TIME_RST 32'h0000_0505
`define AGC_RATE_RST 8'hff

`define AGC_CLK_NS 100
`define AGC_OS_STEP_NS 100
`define AGC_OS_BIAS_NS 50
`define AGC_TC_LOW_IMPEDANCE_IN_NS 13'h012c
`define AGC_TC_R15_NS 13'h1388
`define AGC_TC_R5_NS 13'h05dc
`define AGC_PUMP_STEP_UA 34
`define AGC_IDEAL_ONE_MV 10'h1f4

`endif

/* File: shared/agc_pkg.sv */
// types shared by the gain-control sequencer
package agc_pkg;
    typedef enum logic {AGC_DIRECT, AGC_TIMED} agc_method_e;
    typedef logic [1:0] agc_step_t;
endpackage

/* File: shared/agc_os_if.sv */
// carrier between the sequencer and a one-shot timer
`timescale 1ns/1ps
interface agc_os_if #(parameter int CNT_W = 9);
    logic trig;
    logic [CNT_W-1:0] load;
    logic busy;
    logic expired;
    modport timer(input trig, input load, output busy, output expired);
    modport ctrl(output trig, output load, input busy, input expired);
endinterface

/* File: hdl/agc_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module agc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // s1 is read only by s2 to keep metastability out of the logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    level[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule

/* File: hdl/agc_oneshot.sv */
// retriggerable down-counting one-shot
`timescale 1ns/1ps
module agc_oneshot #(
    parameter int CNT_W = 9
) (
    input wire logic clk,
    input wire logic rst_n,
    agc_os_if.timer os
);
    logic [CNT_W-1:0] count_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (os.trig) begin
            count_reg <= os.load;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign os.busy = (count_reg != '0);
    assign os.expired = (count_reg == CNT_W'(1)) && !os.trig;

    os_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
        os.trig |=> count_reg == $past(os.load))
        else $error("one-shot did not reload on trigger");
endmodule

/* File: hdl/agc_seq.sv */
// gain-control mode sequencer with apb control registers
`timescale 1ns/1ps
`include "agc_regs.svh"
module agc_seq #(
    parameter int SET_W = 8,
    parameter int RATE_W = 8,
    parameter int CNT_W = 9
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic write_gate,
    input wire logic servo_gate,
    input wire logic power_down_in,
    input wire logic low_impedance_in,
    input wire logic fast_recover_in,
    input wire logic hold_in_n,
    input wire logic sync_field_locked,
    input wire logic filtered_signal_at_125,
    input wire logic ultra_fast_pullup_pin,
    input wire logic [9:0] one_sample_mv,
    output agc_pkg::agc_method_e method_active,
    output logic use_servo_store,
    output logic sampled_mode,
    output logic low_impedance_in_active,
    output logic gain_squelch,
    output logic lowimp_ratio_sel,
    output logic [12:0] coupling_tc_ns,
    output logic loop_hold,
    output logic fast_currents,
    output logic store_pullup,
    output logic pump_attack,
    output logic pump_decay,
    output logic [6:0] pump_current_ua
);
    import agc_pkg::*;

    logic [31:0] ctrl_reg;
    logic [31:0] time_reg;
    logic [RATE_W-1:0] rate_reg;
    logic [8:0] pins;
    logic wg_s, sg_s, pd_s, lz_s, fr_s, hold_n_s, lock_s, f125_s, ultra_s;
    logic wg_d_reg, sg_d_reg, pd_d_reg, fr_int_d_reg;
    logic pullup_armed_reg;
    logic low_impedance_in_next, fr_next, hold_next, pullup_next;
    logic setup_ph, access_ph, mapped;
    logic [31:0] rdata_next;
    agc_method_e method_q;
    agc_step_t step_q;
    logic [SET_W-1:0] lz_set, fr_set;
    logic [RATE_W+7:0] pump_prod;

    agc_os_if #(.CNT_W(CNT_W)) lz_os();
    agc_os_if #(.CNT_W(CNT_W)) fr_os();

    assign pins = {ultra_fast_pullup_pin, filtered_signal_at_125,
                   sync_field_locked, hold_in_n, fast_recover_in,
                   low_impedance_in, power_down_in, servo_gate, write_gate};

    agc_sync #(.W(9)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin(pins),
        .level({ultra_s, f125_s, lock_s, hold_n_s, fr_s, lz_s, pd_s,
                sg_s, wg_s})
    );

    agc_oneshot #(.CNT_W(CNT_W)) u_lz_os (
        .clk(clk),
        .rst_n(rst_n),
        .os(lz_os.timer)
    );

    agc_oneshot #(.CNT_W(CNT_W)) u_fr_os (
        .clk(clk),
        .rst_n(rst_n),
        .os(fr_os.timer)
    );

    // apb slave: zero wait states, error on unmapped offsets
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign mapped = (paddr == `AGC_CTRL_OFS) || (paddr == `AGC_TIME_OFS) ||
                    (paddr == `AGC_RATE_OFS) || (paddr == `AGC_STAT_OFS);
    assign pready = 1'b1;
    assign pslverr = access_ph && !mapped;

    always_comb begin
        unique case (paddr)
            `AGC_CTRL_OFS: rdata_next = ctrl_reg;
            `AGC_TIME_OFS: rdata_next = time_reg;
            `AGC_RATE_OFS: rdata_next = {{(32-RATE_W){1'b0}}, rate_reg};
            `AGC_STAT_OFS: rdata_next = {20'h0_0000, pullup_armed_reg,
                                         lz_os.busy, fr_os.busy, loop_hold,
                                         fast_currents, low_impedance_in_active,
                                         sampled_mode, use_servo_store,
                                         lock_s, pd_s, sg_s, wg_s};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // read data is latched in setup so it stands through the access phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata <= rdata_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `AGC_CTRL_RST;
            time_reg <= `AGC_TIME_RST;
            rate_reg <= RATE_W'(`AGC_RATE_RST);
        end else if (access_ph && pwrite) begin
            if (paddr == `AGC_CTRL_OFS) begin
                ctrl_reg <= {25'h0, pwdata[6:0]};
            end
            if (paddr == `AGC_TIME_OFS) begin
                time_reg <= {16'h0000, pwdata[15:0]};
            end
            if (paddr == `AGC_RATE_OFS) begin
                rate_reg <= pwdata[RATE_W-1:0];
            end
        end
    end

    assign method_q = ctrl_reg[`AGC_CTRL_METHOD_BIT] ? AGC_TIMED : AGC_DIRECT;
    assign step_q = ctrl_reg[`AGC_CTRL_STEP_LSB+1:`AGC_CTRL_STEP_LSB];
    assign lz_set = time_reg[SET_W-1:0];
    assign fr_set = time_reg[SET_W+7:8];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wg_d_reg <= 1'b0;
            sg_d_reg <= 1'b0;
            pd_d_reg <= 1'b0;
        end else begin
            wg_d_reg <= wg_s;
            sg_d_reg <= sg_s;
            pd_d_reg <= pd_s;
        end
    end

    // triggers: write end, any servo edge, power-up
    assign lz_os.trig = (method_q == AGC_TIMED) &&
                        ((wg_d_reg && !wg_s) || (sg_d_reg != sg_s) ||
                         (pd_d_reg && !pd_s));
    // length rounded up to whole clocks
    assign lz_os.load = CNT_W'((`AGC_OS_STEP_NS * int'(lz_set) +
                        `AGC_OS_BIAS_NS + `AGC_CLK_NS - 1) / `AGC_CLK_NS);
    assign fr_os.trig = (method_q == AGC_TIMED) && lz_os.expired;
    assign fr_os.load = CNT_W'((`AGC_OS_STEP_NS * int'(fr_set) +
                        `AGC_OS_BIAS_NS + `AGC_CLK_NS - 1) / `AGC_CLK_NS);

    // external controls ORed in, one-shots untouched; is theirs
    always_comb begin
        if (method_q == AGC_TIMED) begin
            low_impedance_in_next = lz_os.busy || wg_s || lz_s;
            fr_next = fr_os.busy || fr_s;
            hold_next = wg_s || pd_s || !hold_n_s;
        end else begin
            low_impedance_in_next = lz_s;
            fr_next = fr_s;
            hold_next = !hold_n_s;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_impedance_in_active <= 1'b0;
            gain_squelch <= 1'b0;
            fast_currents <= 1'b0;
            loop_hold <= 1'b1;
            fr_int_d_reg <= 1'b0;
        end else begin
            low_impedance_in_active <= low_impedance_in_next;
            gain_squelch <= low_impedance_in_next;
            fast_currents <= fr_next;
            loop_hold <= hold_next;
            fr_int_d_reg <= fr_next;
        end
    end

    // arm on recovery entry, disarm at first 125%; entry wins
    assign pullup_next = ultra_s && fr_next && !fr_int_d_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pullup_armed_reg <= 1'b0;
        end else if (pullup_next) begin
            pullup_armed_reg <= 1'b1;
        end else if (f125_s || !ultra_s) begin
            pullup_armed_reg <= 1'b0;
        end
    end
    assign store_pullup = pullup_armed_reg;

    // store select; sampled after lock in data reads
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            use_servo_store <= 1'b0;
            sampled_mode <= 1'b0;
            method_active <= AGC_DIRECT;
        end else begin
            use_servo_store <= sg_s;
            sampled_mode <= !sg_s && lock_s;
            method_active <= method_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowimp_ratio_sel <= 1'b0;
            coupling_tc_ns <= `AGC_TC_R5_NS;
        end else begin
            lowimp_ratio_sel <= ctrl_reg[`AGC_CTRL_RATIO_BIT];
            if (low_impedance_in_next) begin
                coupling_tc_ns <= `AGC_TC_LOW_IMPEDANCE_IN_NS;
            end else if (ctrl_reg[`AGC_CTRL_RATIO_BIT]) begin
                coupling_tc_ns <= `AGC_TC_R15_NS;
            end else begin
                coupling_tc_ns <= `AGC_TC_R5_NS;
            end
        end
    end

    // step current scaled by rate; full rate 2^RATE_W-1 gives full step
    assign pump_prod = (RATE_W+8)'(`AGC_PUMP_STEP_UA * int'(step_q) *
                       (int'(rate_reg) + 1));
    // symmetric pump, error from one-level sample vs ideal
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pump_current_ua <= 7'h00;
            pump_attack <= 1'b0;
            pump_decay <= 1'b0;
        end else begin
            pump_current_ua <= pump_prod[RATE_W+6:RATE_W];
            pump_attack <= !sg_s && lock_s && !hold_next &&
                           (one_sample_mv > `AGC_IDEAL_ONE_MV);
            pump_decay <= !sg_s && lock_s && !hold_next &&
                          (one_sample_mv < `AGC_IDEAL_ONE_MV);
        end
    end

    // checks
    store_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sg_s) |=> use_servo_store && !sampled_mode)
        else $error("servo store not selected");
    sampled_switch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!sg_s && lock_s) |=> sampled_mode)
        else $error("sampled loop not entered after lock");
    pump_symmetric_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(pump_attack && pump_decay))
        else $error("attack and decay together");
    pump_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        (rate_reg == '1 && step_q == 2'h3) |=> pump_current_ua == 7'd102)
        else $error("full-rate pump current wrong");
    direct_low_impedance_in_a: assert property (@(posedge clk) disable iff (!rst_n)
        (method_q == AGC_DIRECT) ##1 (method_q == AGC_DIRECT)
        |-> low_impedance_in_active == $past(lz_s) && gain_squelch == low_impedance_in_active)
        else $error("direct low-impedance not followed");
    tc_low_impedance_in_a: assert property (@(posedge clk) disable iff (!rst_n)
        low_impedance_in_active |-> coupling_tc_ns == 13'd300)
        else $error("coupling time constant wrong in low-impedance");
    hold_pump_a: assert property (@(posedge clk) disable iff (!rst_n)
        loop_hold |-> !pump_attack && !pump_decay)
        else $error("pumps active during hold");
    fast_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        (method_q == AGC_DIRECT && fr_s) |=> fast_currents)
        else $error("fast currents missing");
    pullup_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (f125_s && !pullup_next) |=> !store_pullup)
        else $error("pull-up not released at 125 percent");
    timed_chain_a: assert property (@(posedge clk) disable iff (!rst_n)
        (method_q == AGC_TIMED && lz_os.expired) |=> fr_os.busy)
        else $error("recovery did not follow low-impedance");
    timed_or_a: assert property (@(posedge clk) disable iff (!rst_n)
        (method_q == AGC_TIMED && (wg_s || pd_s)) |=> loop_hold)
        else $error("internal hold missing");
endmodule

/* File: verif/agc_hdc_model.sv */
// disk controller model driving the gate and gain-control pins
`timescale 1ns/1ps
module agc_hdc_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic timed,
    input wire logic override,
    input wire logic [2:0] gate_req,
    input wire logic [2:0] ctl_req,
    output logic write_gate,
    output logic servo_gate,
    output logic power_down_in,
    output logic low_impedance_in,
    output logic fast_recover_in,
    output logic hold_in_n
);
    logic quiet;
    assign quiet = timed && !override;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_gate <= 1'b0;
            servo_gate <= 1'b0;
            power_down_in <= 1'b0;
            low_impedance_in <= 1'b1;
            fast_recover_in <= 1'b0;
            hold_in_n <= 1'b1;
        end else begin
            write_gate <= gate_req[0];
            servo_gate <= gate_req[1];
            power_down_in <= gate_req[2];
            // low-impedance in writes, recovery on request
            low_impedance_in <= !quiet && (ctl_req[0] || gate_req[0]);
            fast_recover_in <= !quiet && ctl_req[1];
            hold_in_n <= quiet || !ctl_req[2];
        end
    end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the gain-control sequencer
`timescale 1ns/1ps
`include "agc_regs.svh"
module testbench;
    import agc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er;
    logic timed = 1'b0, override = 1'b0;
    logic [2:0] gate_req = 3'h0, ctl_req = 3'h0;
    logic write_gate, servo_gate, power_down_in;
    logic low_impedance_in, fast_recover_in, hold_in_n;
    logic sync_field_locked = 1'b0, filtered_signal_at_125 = 1'b0;
    logic ultra_fast_pullup_pin = 1'b0;
    logic [9:0] one_sample_mv = 10'h0;
    agc_method_e method_active;
    logic use_servo_store, sampled_mode, low_impedance_in_active, gain_squelch;
    logic lowimp_ratio_sel, loop_hold, fast_currents, store_pullup;
    logic pump_attack, pump_decay;
    logic [12:0] coupling_tc_ns;
    logic [6:0] pump_current_ua;
    int n_fail = 0, cmp_count = 0, cyc = 0, seed = 13812;
    logic [7:0] rate, lz_set, fr_set;

    always #50 clk = ~clk;

    agc_seq agc_seq_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .write_gate, .servo_gate,
        .power_down_in, .low_impedance_in, .fast_recover_in, .hold_in_n,
        .sync_field_locked, .filtered_signal_at_125, .ultra_fast_pullup_pin,
        .one_sample_mv, .method_active, .use_servo_store, .sampled_mode,
        .low_impedance_in_active, .gain_squelch, .lowimp_ratio_sel, .coupling_tc_ns,
        .loop_hold, .fast_currents, .store_pullup, .pump_attack, .pump_decay,
        .pump_current_ua);

    agc_hdc_model agc_hdc_model_i (.clk, .rst_n, .timed, .override,
        .gate_req, .ctl_req, .write_gate, .servo_gate, .power_down_in,
        .low_impedance_in, .fast_recover_in, .hold_in_n);

    task end_sim;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // a hang is cut short well past the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim;
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: pick = low_impedance_in_active;
            1: pick = gain_squelch;
            2: pick = loop_hold;
            3: pick = fast_currents;
            4: pick = use_servo_store;
            5: pick = sampled_mode;
            6: pick = store_pullup;
            7: pick = pump_attack;
            default: pick = pump_decay;
        endcase
    endfunction

    function automatic logic [6:0] pump_exp(input int s, input int r);
        pump_exp = 7'((34 * s * (r + 1)) >> 8);
    endfunction

    // pins pass a synchroniser, so levels are given a bounded settling time
    task wait_lvl(input int k, input logic v, input string nm);
        int n;
        n = 0;
        @(negedge clk);
        while (pick(k) !== v && n < 12) begin
            @(negedge clk);
            n++;
        end
        chk(nm, 32'(pick(k)), 32'(v));
        @(posedge clk);
    endtask

    // entered at a negedge, so a pulse that rose on the posedge half a cycle ago still counts in full
    task pulse(input int k, input int exp, input string nm);
        int n;
        n = 0;
        while (pick(k) !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (pick(k) === 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(nm, 32'(n), 32'(exp));
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20)
            n_fail++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        chk("hold in reset", 32'(loop_hold), 32'h1);
        chk("tc in reset", 32'(coupling_tc_ns), 32'h5dc);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, `AGC_TIME_OFS, 32'h0);
        chk("time reset", rd, 32'h505);
        apb(1'b0, `AGC_RATE_OFS, 32'h0);
        chk("rate reset", rd, 32'hff);
        apb(1'b1, 8'h10, 32'hffff_ffff);
        chk("unmapped err", 32'(er), 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped data", rd, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rate = (i == 3 || i == 4) ? 8'hff :
                   (i == 5) ? 8'h00 : 8'($random(seed));
            apb(1'b1, `AGC_RATE_OFS, {24'h0, rate});
            apb(1'b1, `AGC_CTRL_OFS, 32'((i % 4) << 1));
            @(negedge clk);
            chk("pump current", 32'(pump_current_ua), 32'(pump_exp(i % 4, rate)));
            @(posedge clk);
        end
        apb(1'b1, `AGC_CTRL_OFS, 32'h1);
        @(negedge clk);
        chk("method", 32'(method_active), 32'(AGC_DIRECT));
        chk("ratio", 32'(lowimp_ratio_sel), 32'h1);
        chk("tc wide", 32'(coupling_tc_ns), 32'h1388);
        ctl_req <= 3'h1;
        wait_lvl(0, 1'b1, "low_impedance_in on");
        wait_lvl(1, 1'b1, "squelch");
        chk("tc low_impedance_in", 32'(coupling_tc_ns), 32'h12c);
        ctl_req <= 3'h4;
        wait_lvl(0, 1'b0, "low_impedance_in off");
        wait_lvl(2, 1'b1, "hold on");
        ctl_req <= 3'h2;
        ultra_fast_pullup_pin <= 1'b1;
        wait_lvl(2, 1'b0, "hold off");
        wait_lvl(3, 1'b1, "fast on");
        wait_lvl(6, 1'b1, "pullup on");
        filtered_signal_at_125 <= 1'b1;
        wait_lvl(6, 1'b0, "pullup off");
        chk("fast kept", 32'(fast_currents), 32'h1);
        ctl_req <= 3'h0;
        wait_lvl(3, 1'b0, "fast off");
        apb(1'b1, `AGC_CTRL_OFS, 32'h0);
        @(negedge clk);
        chk("tc narrow", 32'(coupling_tc_ns), 32'h5dc);
        @(posedge clk);
        sync_field_locked <= 1'b1;
        gate_req <= 3'h2;
        wait_lvl(4, 1'b1, "servo store");
        wait_lvl(5, 1'b0, "servo cont");
        gate_req <= 3'h0;
        one_sample_mv <= 10'h258;
        wait_lvl(4, 1'b0, "data store");
        wait_lvl(5, 1'b1, "sampled");
        wait_lvl(7, 1'b1, "attack");
        chk("no decay", 32'(pump_decay), 32'h0);
        one_sample_mv <= 10'h190;
        wait_lvl(8, 1'b1, "decay");
        chk("no attack", 32'(pump_attack), 32'h0);
        sync_field_locked <= 1'b0;
        wait_lvl(5, 1'b0, "unlocked");
        lz_set = 8'(1 + ($random(seed) & 7));
        fr_set = 8'(1 + ($random(seed) & 7));
        apb(1'b1, `AGC_TIME_OFS, {16'h0, fr_set, lz_set});
        apb(1'b1, `AGC_CTRL_OFS, 32'h40);
        timed <= 1'b1;
        @(negedge clk);
        chk("timed", 32'(method_active), 32'(AGC_TIMED));
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            gate_req <= 3'(2 - 2 * e);
            @(negedge clk);
            pulse(0, lz_set + 1, "low_impedance_in shot");
            // recovery rises on the edge where low-impedance falls
            pulse(3, fr_set + 1, "fast shot");
        end
        @(posedge clk);
        gate_req <= 3'h1;
        wait_lvl(2, 1'b1, "write hold");
        wait_lvl(0, 1'b1, "write low_impedance_in");
        gate_req <= 3'h0;
        wait_lvl(2, 1'b0, "write hold end");
        gate_req <= 3'h4;
        wait_lvl(2, 1'b1, "pd hold");
        gate_req <= 3'h0;
        wait_lvl(2, 1'b0, "hold clear");
        override <= 1'b1;
        ctl_req <= 3'h2;
        repeat (30) @(posedge clk);
        wait_lvl(3, 1'b1, "ored fast");
        ctl_req <= 3'h0;
        wait_lvl(3, 1'b0, "ored off");
        end_sim;
    end
endmodule
